// >>> src/mei_pkg.sv
package mei_pkg;

  // ----------------------------------------------------------------------
  // event types and masks
  // ----------------------------------------------------------------------
  localparam int NTYPES = 17;
  localparam logic [4:0] T_FLUSH = 5'h01;
  localparam logic [4:0] T_RATE = 5'h02;
  localparam logic [4:0] T_POWER = 5'h03;
  localparam logic [4:0] T_ERROR = 5'h04;
  localparam logic [4:0] T_SENSERR = 5'h0b;
  localparam logic [4:0] T_OVF = 5'h0c;
  localparam logic [4:0] T_RANGE = 5'h0d;
  localparam logic [4:0] T_WMARK = 5'h0e;
  localparam logic [4:0] T_SELFTEST = 5'h0f;
  localparam logic [4:0] T_INIT = 5'h10;
  // types 0 and 5..10 can never be enabled
  localparam logic [16:0] TYPE_VALID = 17'h1f81e;
  localparam logic [16:0] EN_WAKE_RST = 17'h1b816;
  localparam logic [16:0] EN_NWAKE_RST = 17'h1a816;
  localparam logic [16:0] IE_WAKE_RST = 17'h10810;
  localparam logic [16:0] IE_NWAKE_RST = 17'h18810;

  // ----------------------------------------------------------------------
  // record layout
  // ----------------------------------------------------------------------
  localparam logic [7:0] META_ID = 8'hfe;
  localparam logic [7:0] TSU_ID = 8'hfd;
  localparam logic [7:0] TSL_ID = 8'hfc;
  localparam logic [2:0] REC_LEN_META = 3'h4;
  localparam logic [2:0] REC_LEN_TS = 3'h3;
  localparam logic [7:0] DROP_BYTES = 8'hc8;
  localparam logic [15:0] LOST_MAX = 16'hffff;
  localparam logic FIFO_NWAKE = 1'b0;
  localparam logic FIFO_WAKE = 1'b1;

  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [4:0] REG_EN_WAKE = 5'h00;
  localparam logic [4:0] REG_EN_NWAKE = 5'h04;
  localparam logic [4:0] REG_IE_WAKE = 5'h08;
  localparam logic [4:0] REG_IE_NWAKE = 5'h0c;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam logic [4:0] REG_LOST_WAKE = 5'h14;
  localparam logic [4:0] REG_LOST_NWAKE = 5'h18;
  localparam int ST_IRQ_LSB = 0;
  localparam int ST_PEND_LSB = 2;
  localparam int ST_INIT_LSB = 4;

  typedef enum {ST_IDLE, ST_SAMP} mei_state_e;
  typedef enum {J_NONE, J_TSU, J_TSL, J_META, J_GRANT} mei_job_e;

endpackage

// >>> src/mei_byte_ser.sv
`timescale 1ns/1ps
module mei_byte_ser
  import mei_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic reset, // synchronous, active high
  input wire logic in_valid, // record offered
  output logic in_ready, // record accepted when valid
  input wire logic [2:0] in_len, // bytes in record
  input wire logic [31:0] in_data, // first byte in low lane
  output logic out_valid, // byte available
  output logic [7:0] out_data, // byte to fifo
  input wire logic out_ready, // fifo takes byte
  output logic idle // nothing in flight
);

  logic [31:0] sh_ff;
  logic [31:0] nxt_sh;
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;

  assign in_ready = (cnt_ff == 3'h0);
  assign idle = (cnt_ff == 3'h0);
  assign out_valid = (cnt_ff != 3'h0);
  assign out_data = sh_ff[7:0];

  always_comb
  begin
    nxt_sh = sh_ff;
    nxt_cnt = cnt_ff;
    if (in_valid && in_ready)
    begin
      nxt_sh = in_data;
      nxt_cnt = in_len;
    end
    else if (out_valid && out_ready)
    begin
      nxt_sh = {8'h00, sh_ff[31:8]};
      nxt_cnt = cnt_ff - 3'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sh_ff <= 32'h0;
      cnt_ff <= 3'h0;
    end
    else
    begin
      sh_ff <= nxt_sh;
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

// >>> src/mei_inserter.sv
`timescale 1ns/1ps
module mei_inserter
  import mei_pkg::*;
#(
  parameter logic [15:0] RAM_VERSION = 16'h0001 // loaded image version
)
(
  input wire logic clk, // 100 MHz system clock
  input wire logic reset, // synchronous, active high
  input wire logic [4:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic [31:0] now_ts, // current timestamp
  input wire logic flush_stb, // flush request done
  input wire logic [7:0] flush_sensor, // sensor of flush
  input wire logic rate_stb, // rate took effect
  input wire logic [7:0] rate_sensor, // sensor of rate change
  input wire logic power_stb, // sensor powered up or down
  input wire logic [7:0] power_sensor, // sensor of power change
  input wire logic [7:0] power_mode, // new power mode
  input wire logic error_stb, // internal firmware error
  input wire logic [7:0] error_code, // error register value
  input wire logic [7:0] error_debug, // debug state
  input wire logic senserr_stb, // sensor failure
  input wire logic [7:0] senserr_sensor, // failing sensor
  input wire logic [7:0] senserr_status, // nack / id mismatch bits
  input wire logic range_stb, // range change took effect
  input wire logic [7:0] range_sensor, // sensor of range change
  input wire logic wmark_stb, // watermark reached
  input wire logic [15:0] wmark_remaining, // bytes remaining
  input wire logic selftest_stb, // self-test finished
  input wire logic [7:0] selftest_sensor, // tested sensor
  input wire logic [2:0] selftest_result, // z,y,x fail bits
  input wire logic ovf_stb, // fifo overflowed
  input wire logic ovf_wake, // overflowed fifo is wakeup
  input wire logic [15:0] ovf_bytes, // bytes lost now
  output logic drop_req, // discard oldest data
  output logic drop_wake, // discard in wakeup fifo
  output logic [7:0] drop_bytes, // bytes to discard
  input wire logic samp_req, // sample waiting
  input wire logic samp_wake, // sample for wakeup fifo
  input wire logic [31:0] samp_ts, // sample timestamp
  output logic samp_grant, // sample may be written
  input wire logic samp_done, // sample written
  output logic out_valid, // record byte valid
  output logic [7:0] out_data, // record byte
  output logic out_wake, // byte goes to wakeup fifo
  input wire logic out_ready, // fifo takes byte
  output logic irq_wake, // host interrupt, wakeup fifo
  output logic irq_nwake // host interrupt, non-wakeup fifo
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic [16:0] en_ff [2];
  logic [16:0] nxt_en [2];
  logic [16:0] ie_ff [2];
  logic [16:0] nxt_ie [2];
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic rd_ack_ff;
  logic nxt_rd_ack;
  mei_state_e state_ff;
  mei_state_e nxt_state;
  logic [16:0] pend_ff [2];
  logic [16:0] nxt_pend [2];
  logic [15:0] pay_ff [NTYPES];
  logic [15:0] nxt_pay [NTYPES];
  logic [15:0] lost_ff [2];
  logic [15:0] nxt_lost [2];
  logic [15:0] last_hi_ff [2];
  logic [15:0] nxt_last_hi [2];
  logic [15:0] last_lo_ff [2];
  logic [15:0] nxt_last_lo [2];
  logic [1:0] ovf_pend_ff, nxt_ovf_pend, fhi_ff, nxt_fhi, flo_ff, nxt_flo;
  logic [1:0] irq_ff, nxt_irq, init_done_ff, nxt_init_done;
  logic drop_req_ff, nxt_drop_req, drop_wake_ff, nxt_drop_wake;
  logic cur_wake_ff, nxt_cur_wake;
  logic [16:0] stb;
  logic [15:0] pay [NTYPES];
  logic [1:0] work;
  logic sel;
  mei_job_e job;
  logic [4:0] job_type;
  logic [31:0] rec_data;
  logic [2:0] rec_len;
  logic [16:0] sum_lost;
  logic rec_valid, rec_ready, rec_take, ser_idle, irq_clr_wr;

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = avs_read & ~rd_ack_ff;
  assign irq_wake = irq_ff[FIFO_WAKE];
  assign irq_nwake = irq_ff[FIFO_NWAKE];
  assign drop_req = drop_req_ff;
  assign drop_wake = drop_wake_ff;
  assign drop_bytes = DROP_BYTES;
  assign out_wake = cur_wake_ff;
  assign samp_grant = (state_ff == ST_SAMP);
  assign irq_clr_wr = avs_write && (avs_address == REG_STATUS);

  // ----------------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------------
  // reads take one wait cycle so read data comes straight from a flop
  always_comb
  begin
    nxt_en = en_ff;
    nxt_ie = ie_ff;
    nxt_rd_ack = avs_read & ~rd_ack_ff;
    nxt_rdata = rdata_ff;
    if (avs_read && !rd_ack_ff)
    begin
      case (avs_address)
        REG_EN_WAKE: nxt_rdata = {15'h0, en_ff[FIFO_WAKE]};
        REG_EN_NWAKE: nxt_rdata = {15'h0, en_ff[FIFO_NWAKE]};
        REG_IE_WAKE: nxt_rdata = {15'h0, ie_ff[FIFO_WAKE]};
        REG_IE_NWAKE: nxt_rdata = {15'h0, ie_ff[FIFO_NWAKE]};
        REG_STATUS: nxt_rdata = {27'h0, init_done_ff[0] & init_done_ff[1], ovf_pend_ff, irq_ff};
        REG_LOST_WAKE: nxt_rdata = {16'h0, lost_ff[FIFO_WAKE]};
        REG_LOST_NWAKE: nxt_rdata = {16'h0, lost_ff[FIFO_NWAKE]};
        default: nxt_rdata = 32'h0;
      endcase
    end
    if (avs_write)
    begin
      case (avs_address)
        REG_EN_WAKE: nxt_en[FIFO_WAKE] = avs_writedata[16:0] & TYPE_VALID;
        REG_EN_NWAKE: nxt_en[FIFO_NWAKE] = avs_writedata[16:0] & TYPE_VALID;
        REG_IE_WAKE: nxt_ie[FIFO_WAKE] = avs_writedata[16:0] & TYPE_VALID;
        REG_IE_NWAKE: nxt_ie[FIFO_NWAKE] = avs_writedata[16:0] & TYPE_VALID;
        default: nxt_rdata = nxt_rdata;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      en_ff[FIFO_WAKE] <= EN_WAKE_RST;
      en_ff[FIFO_NWAKE] <= EN_NWAKE_RST;
      ie_ff[FIFO_WAKE] <= IE_WAKE_RST;
      ie_ff[FIFO_NWAKE] <= IE_NWAKE_RST;
      rdata_ff <= 32'h0;
      rd_ack_ff <= 1'b0;
    end
    else
    begin
      en_ff <= nxt_en;
      ie_ff <= nxt_ie;
      rdata_ff <= nxt_rdata;
      rd_ack_ff <= nxt_rd_ack;
    end
  end

  // ----------------------------------------------------------------------
  // record engine
  // ----------------------------------------------------------------------
  always_comb
  begin
    stb = 17'h0;
    for (int t = 0; t < NTYPES; t++)
    begin
      pay[t] = 16'h0;
    end
    stb[T_FLUSH] = flush_stb;
    pay[T_FLUSH] = {8'h00, flush_sensor};
    stb[T_RATE] = rate_stb;
    pay[T_RATE] = {8'h00, rate_sensor};
    stb[T_POWER] = power_stb;
    pay[T_POWER] = {power_mode, power_sensor};
    stb[T_ERROR] = error_stb;
    pay[T_ERROR] = {error_debug, error_code};
    stb[T_SENSERR] = senserr_stb;
    pay[T_SENSERR] = {senserr_status, senserr_sensor};
    stb[T_RANGE] = range_stb;
    pay[T_RANGE] = {8'h00, range_sensor};
    stb[T_WMARK] = wmark_stb;
    pay[T_WMARK] = wmark_remaining;
    stb[T_SELFTEST] = selftest_stb;
    pay[T_SELFTEST] = {5'h00, selftest_result, selftest_sensor};
    pay[T_INIT] = RAM_VERSION;
    for (int t = 0; t < NTYPES; t++)
    begin
      nxt_pay[t] = stb[t] ? pay[t] : pay_ff[t];
    end
    nxt_pay[T_INIT] = RAM_VERSION;

    for (int f = 0; f < 2; f++)
    begin
      work[f] = fhi_ff[f] | flo_ff[f] | ovf_pend_ff[f] | (|pend_ff[f])
        | (samp_req && (samp_wake == f[0]));
    end
    sel = work[FIFO_WAKE];

    // forced timestamps, then init (it must lead every meta event), overflow, lowest type
    job = J_NONE;
    job_type = 5'h0;
    if (fhi_ff[sel])
      job = J_TSU;
    else if (flo_ff[sel])
      job = J_TSL;
    else if (pend_ff[sel][T_INIT])
    begin
      job = J_META;
      job_type = T_INIT;
    end
    else if (ovf_pend_ff[sel])
    begin
      job = J_META;
      job_type = T_OVF;
    end
    else if (|pend_ff[sel])
    begin
      job = J_META;
      for (int t = NTYPES - 1; t >= 0; t--)
      begin
        if (pend_ff[sel][t])
          job_type = 5'(t);
      end
    end
    else if (work[sel])
    begin
      if (samp_ts[31:16] != last_hi_ff[sel])
        job = J_TSU;
      else if (samp_ts[15:0] != last_lo_ff[sel])
        job = J_TSL;
      else
        job = J_GRANT;
    end

    rec_len = REC_LEN_TS;
    rec_data = 32'h0;
    unique case (job)
      J_TSU: rec_data = {8'h00, (fhi_ff[sel] ? now_ts[31:16] : samp_ts[31:16]), TSU_ID};
      J_TSL: rec_data = {8'h00, (flo_ff[sel] ? now_ts[15:0] : samp_ts[15:0]), TSL_ID};
      J_META:
      begin
        rec_len = REC_LEN_META;
        rec_data = {(job_type == T_OVF) ? lost_ff[sel] : pay_ff[job_type],
          3'h0, job_type, META_ID};
      end
      J_NONE, J_GRANT: rec_data = 32'h0;
    endcase
    rec_valid = (state_ff == ST_IDLE) && (job == J_TSU || job == J_TSL || job == J_META);
    rec_take = rec_valid && rec_ready;

    nxt_state = state_ff;
    nxt_cur_wake = rec_take ? sel : cur_wake_ff;
    nxt_fhi = fhi_ff;
    nxt_flo = flo_ff;
    nxt_ovf_pend = ovf_pend_ff;
    nxt_irq = irq_ff;
    nxt_init_done = init_done_ff;
    nxt_last_hi = last_hi_ff;
    nxt_last_lo = last_lo_ff;
    nxt_lost = lost_ff;
    nxt_drop_req = ovf_stb;
    nxt_drop_wake = ovf_stb ? ovf_wake : drop_wake_ff;
    unique case (state_ff)
      ST_IDLE:
        if (job == J_GRANT && ser_idle)
          nxt_state = ST_SAMP;
      ST_SAMP:
        if (samp_done)
          nxt_state = ST_IDLE;
    endcase

    for (int f = 0; f < 2; f++)
    begin
      nxt_pend[f] = pend_ff[f];
      if (rec_take && sel == f[0])
      begin
        if (job == J_TSU)
        begin
          nxt_fhi[f] = 1'b0;
          nxt_last_hi[f] = rec_data[23:8];
        end
        if (job == J_TSL)
        begin
          nxt_flo[f] = 1'b0;
          nxt_last_lo[f] = rec_data[23:8];
        end
        if (job == J_META)
        begin
          nxt_pend[f][job_type] = 1'b0;
          if (ie_ff[f][job_type])
            nxt_irq[f] = 1'b1;
          if (job_type == T_INIT)
            nxt_init_done[f] = 1'b1;
          if (job_type == T_OVF)
          begin
            nxt_ovf_pend[f] = 1'b0;
            nxt_lost[f] = 16'h0;
            nxt_fhi[f] = 1'b1;
            nxt_flo[f] = 1'b1;
          end
        end
      end
      // new events win over the clear of the same cycle
      nxt_pend[f] = nxt_pend[f] | (stb & en_ff[f] & TYPE_VALID);
      if (irq_clr_wr && avs_writedata[ST_IRQ_LSB + f] && !(nxt_irq[f] && !irq_ff[f]))
        nxt_irq[f] = 1'b0;
      if (ovf_stb && ovf_wake == f[0])
      begin
        sum_lost = {1'b0, nxt_lost[f]} + {1'b0, ovf_bytes};
        nxt_lost[f] = sum_lost[16] ? LOST_MAX : sum_lost[15:0];
        if (en_ff[f][T_OVF])
          nxt_ovf_pend[f] = 1'b1;
      end
    end
    sum_lost = 17'h0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_ff <= ST_IDLE;
      for (int f = 0; f < 2; f++)
      begin
        pend_ff[f] <= 17'h0;
        lost_ff[f] <= 16'h0;
        last_hi_ff[f] <= 16'h0;
        last_lo_ff[f] <= 16'h0;
      end
      pend_ff[FIFO_WAKE][T_INIT] <= 1'b1;
      pend_ff[FIFO_NWAKE][T_INIT] <= 1'b1;
      for (int t = 0; t < NTYPES; t++)
      begin
        pay_ff[t] <= 16'h0;
      end
      pay_ff[T_INIT] <= RAM_VERSION;
      fhi_ff <= 2'h3;
      flo_ff <= 2'h3;
      ovf_pend_ff <= 2'h0;
      irq_ff <= 2'h0;
      init_done_ff <= 2'h0;
      drop_req_ff <= 1'b0;
      drop_wake_ff <= 1'b0;
      cur_wake_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      pend_ff <= nxt_pend;
      lost_ff <= nxt_lost;
      last_hi_ff <= nxt_last_hi;
      last_lo_ff <= nxt_last_lo;
      pay_ff <= nxt_pay;
      fhi_ff <= nxt_fhi;
      flo_ff <= nxt_flo;
      ovf_pend_ff <= nxt_ovf_pend;
      irq_ff <= nxt_irq;
      init_done_ff <= nxt_init_done;
      drop_req_ff <= nxt_drop_req;
      drop_wake_ff <= nxt_drop_wake;
      cur_wake_ff <= nxt_cur_wake;
    end
  end

  mei_byte_ser u_ser (
    .clk(clk),
    .reset(reset),
    .in_valid(rec_valid),
    .in_ready(rec_ready),
    .in_len(rec_len),
    .in_data(rec_data),
    .out_valid(out_valid),
    .out_data(out_data),
    .out_ready(out_ready),
    .idle(ser_idle)
  );

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_NO_RESERVED: assert property (rec_take && job == J_META |-> TYPE_VALID[job_type])
    else $error("reserved meta type emitted");
  AST_IRQ_RAISE: assert property (rec_take && job == J_META && ie_ff[sel][job_type]
    |=> irq_ff[$past(sel)])
    else $error("interrupt not raised");
  AST_INIT_FIRST: assert property (rec_take && job == J_META && !init_done_ff[sel]
    |-> job_type == T_INIT)
    else $error("first meta event is not init");
  AST_META_LEN: assert property (rec_valid && rec_data[7:0] == META_ID
    |-> rec_len == REC_LEN_META)
    else $error("meta record length wrong");
  AST_FLUSH_QUEUED: assert property (flush_stb && en_ff[FIFO_WAKE][T_FLUSH]
    |=> pend_ff[FIFO_WAKE][T_FLUSH] || $past(rec_take))
    else $error("flush event lost");
  AST_OVF_TS: assert property (rec_take && job == J_META && job_type == T_OVF
    |=> fhi_ff[$past(sel)] ##1 (fhi_ff[$past(sel, 2)] || flo_ff[$past(sel, 2)]))
    else $error("timestamps do not follow overflow");
  AST_DROP: assert property (ovf_stb |=> drop_req && drop_bytes == DROP_BYTES)
    else $error("overflow discard missing");
  AST_LOST_SAT: assert property (ovf_stb && lost_ff[ovf_wake] == LOST_MAX && !rec_take
    |=> lost_ff[$past(ovf_wake)] == LOST_MAX)
    else $error("lost count wrapped");
  AST_GRANT_TS: assert property ($rose(samp_grant)
    |-> last_lo_ff[samp_wake] == samp_ts[15:0] && last_hi_ff[samp_wake] == samp_ts[31:16])
    else $error("sample granted without matching timestamp");

  COV_INIT: cover property (rec_take && job_type == T_INIT && job == J_META);
  COV_OVF: cover property (rec_take && job_type == T_OVF ##[1:20] rec_take && job == J_TSL);
  COV_SAMP: cover property ($rose(samp_grant));

endmodule

// >>> verif/mei_fifo_sink.sv
`timescale 1ns/1ps
module mei_fifo_sink (
  input wire logic clk, // system clock
  input wire logic stall, // slow drain mode
  input wire logic out_valid, // byte offered
  input wire logic [7:0] out_data, // offered byte
  input wire logic out_wake, // target fifo
  output logic out_ready // byte taken
);
  logic [8:0] q[$];
  logic ph_ff = 1'b0;
  // slow mode takes a byte only on every other cycle, like a host falling behind
  assign out_ready = !stall || ph_ff;
  always @(posedge clk)
  begin
    ph_ff <= !ph_ff;
    if (out_valid === 1'b1 && out_ready)
      q.push_back({out_wake, out_data});
  end
endmodule

// >>> verif/meta_event_fifo_inserter_test.sv
`timescale 1ns/1ps
module meta_event_fifo_inserter_test;
  import mei_pkg::*;
  typedef struct packed {logic [8:0] m; logic [7:0] t, x, y; logic [3:0] f;} mei_row_s;
  localparam logic [31:0] TS0 = 32'h12345678;
  logic clk = 1'b0, reset = 1'b1, rd = 1'b0, wr = 1'b0, ovw = 1'b0, stall = 1'b0;
  logic sreq = 1'b0, sdone = 1'b0, swk = 1'b0;
  logic [4:0] adr = '0;
  logic [31:0] wd = '0, sts = '0, nts = TS0, r;
  logic [8:0] stb = '0;
  logic [7:0] b1 = '0, b2 = '0;
  logic [9:0] drop_seen;
  wire logic [31:0] rdat;
  wire logic [7:0] dby, od;
  wire logic wreq, drq, dwk, sgnt, ov, owk, ordy, iw, inw;
  int bad_count = 0, samples_checked = 0;
  logic [8:0] eq[$];
  // f: enabled wake, enabled nwake, irq wake, irq nwake
  mei_row_s rows[9] = '{
    '{9'h001, 8'h01, 8'h21, 8'h00, 4'hc},
    '{9'h002, 8'h02, 8'h22, 8'h00, 4'hc},
    '{9'h004, 8'h03, 8'h23, 8'h05, 4'h0},
    '{9'h008, 8'h04, 8'he1, 8'hd2, 4'hf},
    '{9'h010, 8'h0b, 8'h24, 8'h03, 4'hf},
    '{9'h020, 8'h0d, 8'h25, 8'h00, 4'hc},
    '{9'h040, 8'h0e, 8'h34, 8'h12, 4'h0},
    '{9'h080, 8'h0f, 8'h26, 8'h00, 4'hd},
    '{9'h080, 8'h0f, 8'h27, 8'h07, 4'hd}};

  mei_inserter u_dut (.clk(clk), .reset(reset), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .now_ts(nts), .flush_stb(stb[0]), .flush_sensor(b1), .rate_stb(stb[1]),
    .rate_sensor(b1), .power_stb(stb[2]), .power_sensor(b1), .power_mode(b2),
    .error_stb(stb[3]), .error_code(b1), .error_debug(b2), .senserr_stb(stb[4]),
    .senserr_sensor(b1), .senserr_status(b2), .range_stb(stb[5]), .range_sensor(b1),
    .wmark_stb(stb[6]), .wmark_remaining({b2, b1}), .selftest_stb(stb[7]),
    .selftest_sensor(b1), .selftest_result(b2[2:0]), .ovf_stb(stb[8]), .ovf_wake(ovw),
    .ovf_bytes({b2, b1}), .drop_req(drq), .drop_wake(dwk), .drop_bytes(dby),
    .samp_req(sreq), .samp_wake(swk), .samp_ts(sts), .samp_grant(sgnt),
    .samp_done(sdone), .out_valid(ov), .out_data(od), .out_wake(owk), .out_ready(ordy),
    .irq_wake(iw), .irq_nwake(inw));
  mei_fifo_sink u_sink (.clk(clk), .stall(stall), .out_valid(ov), .out_data(od),
    .out_wake(owk), .out_ready(ordy));

  initial
  begin
    forever #5 clk = !clk;
  end

  // ----
  // helpers
  // ----
  task results;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task tmo(input string n);
    bad_count++;
    $display("mismatch %s expected done seen timeout", n);
    results();
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(negedge clk);
    while (wreq !== 1'b0)
    begin
      i++;
      if (i > 50)
        tmo("bus");
      @(negedge clk);
    end
    @(posedge clk);
    r = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task sig(input logic [8:0] m, input logic [7:0] x, input logic [7:0] y);
    @(posedge clk);
    stb <= m;
    b1 <= x;
    b2 <= y;
    @(posedge clk);
    stb <= '0;
    @(negedge clk);
    drop_seen = {drq, dwk, dby};
  endtask

  function void meta(input logic w, input logic [7:0] t, x, y);
    eq.push_back({w, META_ID});
    eq.push_back({w, t});
    eq.push_back({w, x});
    eq.push_back({w, y});
  endfunction

  function void ts(input logic w, input logic [7:0] id, input logic [15:0] v);
    eq.push_back({w, id});
    eq.push_back({w, v[7:0]});
    eq.push_back({w, v[15:8]});
  endfunction

  // extra idle cycles catch any record that should not be there
  task cmpq(input string n);
    int i;
    i = 0;
    while (u_sink.q.size() < eq.size())
    begin
      i++;
      if (i > 400)
        tmo(n);
      @(posedge clk);
    end
    repeat (12) @(posedge clk);
    chk({n, " count"}, eq.size(), u_sink.q.size());
    foreach (eq[k])
      if (k < u_sink.q.size())
        chk(n, {23'h0, eq[k]}, {23'h0, u_sink.q[k]});
    eq.delete();
    u_sink.q.delete();
  endtask

  task samp(input logic w, input logic [31:0] t);
    int i;
    i = 0;
    @(posedge clk);
    sreq <= 1'b1;
    swk <= w;
    sts <= t;
    @(negedge clk);
    while (sgnt !== 1'b1)
    begin
      i++;
      if (i > 100)
        tmo("grant");
      @(negedge clk);
    end
    @(posedge clk);
    sdone <= 1'b1;
    sreq <= 1'b0;
    @(posedge clk);
    sdone <= 1'b0;
    cmpq("sample");
  endtask

  task boot;
    for (int w = 1; w >= 0; w--)
    begin
      ts(w[0], TSU_ID, TS0[31:16]);
      ts(w[0], TSL_ID, TS0[15:0]);
      meta(w[0], 8'h10, 8'h01, 8'h00);
    end
    cmpq("boot");
  endtask

  // ----
  // sequence
  // ----
  initial
  begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    boot();
    bus(1'b0, REG_STATUS, '0);
    chk("status", 32'h13, r);
    bus(1'b1, REG_STATUS, 32'h3);
    bus(1'b0, REG_EN_WAKE, '0);
    chk("en wake", EN_WAKE_RST, r);
    bus(1'b0, REG_IE_NWAKE, '0);
    chk("ie nwake", IE_NWAKE_RST, r);
    bus(1'b0, 5'h1c, '0);
    chk("unmapped", '0, r);
    stall <= 1'b1;
    foreach (rows[i])
    begin
      sig(rows[i].m, rows[i].x, rows[i].y);
      if (rows[i].f[3])
        meta(1'b1, rows[i].t, rows[i].x, rows[i].y);
      if (rows[i].f[2])
        meta(1'b0, rows[i].t, rows[i].x, rows[i].y);
      cmpq("row");
      bus(1'b0, REG_STATUS, '0);
      chk("irq", {27'h0, 3'h4, rows[i].f[1:0]}, r);
      bus(1'b1, REG_STATUS, 32'h3);
    end
    bus(1'b1, REG_EN_WAKE, 32'hffffffff);
    bus(1'b0, REG_EN_WAKE, '0);
    chk("reserved", TYPE_VALID, r);
    sig(9'h004, 8'h28, 8'h01);
    meta(1'b1, 8'h03, 8'h28, 8'h01);
    cmpq("power");
    // a moved clock shows that the forced timestamps carry the time at emission
    nts <= TS0 + 32'h10001;
    ovw <= 1'b1;
    sig(9'h100, 8'h23, 8'h01);
    chk("drop", {2'b11, 8'hc8}, drop_seen);
    meta(1'b1, 8'h0c, 8'h23, 8'h01);
    ts(1'b1, TSU_ID, TS0[31:16] + 16'h1);
    ts(1'b1, TSL_ID, TS0[15:0] + 16'h1);
    cmpq("overflow");
    nts <= TS0;
    bus(1'b0, REG_LOST_WAKE, '0);
    chk("lost", 32'h0, r);
    ovw <= 1'b0;
    sig(9'h100, 8'h10, 8'h00);
    chk("drop nwake", {2'b10, 8'hc8}, drop_seen);
    cmpq("ovf nwake");
    bus(1'b0, REG_LOST_NWAKE, '0);
    chk("lost nwake", 32'h10, r);
    repeat (2) sig(9'h100, 8'hff, 8'hff);
    bus(1'b0, REG_LOST_NWAKE, '0);
    chk("lost sat", 32'hffff, r);
    stall <= 1'b0;
    ts(1'b1, TSU_ID, TS0[31:16]);
    ts(1'b1, TSL_ID, TS0[15:0]);
    samp(1'b1, TS0);
    ts(1'b1, TSL_ID, TS0[15:0] + 16'h1);
    samp(1'b1, TS0 + 32'h1);
    ts(1'b1, TSU_ID, TS0[31:16] + 16'h1);
    samp(1'b1, TS0 + 32'h10001);
    samp(1'b1, TS0 + 32'h10001);
    ts(1'b0, TSU_ID, TS0[31:16] + 16'h1);
    ts(1'b0, TSL_ID, TS0[15:0] + 16'h1);
    samp(1'b0, TS0 + 32'h10001);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    boot();
    bus(1'b0, REG_LOST_NWAKE, '0);
    chk("lost reset", 32'h0, r);
    results();
  end
endmodule
